// ==== csr_pkg.sv ====
`default_nettype none
package csr_pkg;
    localparam logic [3:0] OFF_KEY      = 4'h4;
    localparam logic [3:0] OFF_EXT_PTR  = 4'hb;
    localparam logic [3:0] OFF_SP_LOW   = 4'hd;
    localparam logic [3:0] OFF_SP_HIGH  = 4'he;
    localparam logic [3:0] OFF_FLAGS    = 4'hf;

    localparam logic [7:0] KEY_RESET    = 8'h00;
    localparam logic [7:0] EXT_RESET    = 8'h00;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    localparam logic [15:0] SRAM_TOP    = 16'h7fff;

    localparam logic [7:0] SELF_PROGRAM_SIGNATURE = 8'h9d;
    localparam logic [7:0] IO_UNLOCK_SIGNATURE    = 8'hd8;
    localparam int KEY_IO_BIT  = 0;
    localparam int KEY_SPM_BIT = 1;

    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;

    localparam logic [2:0] WINDOW_INSTRS = 3'h4;

    localparam logic [15:0] FLASH_DATA_BASE = 16'h8000;
    localparam int FLASH_SECTION_BITS = 15;
    localparam int FLASH_PAGE_BITS    = 9;
    localparam int FLASH_PAGES        = 256;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } csr_io_req_t;

    typedef struct packed {
        logic upd_h;
        logic upd_vnzc;
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } csr_alu_flags_t;

    typedef enum logic [2:0] {
        WIN_IDLE = 3'b001,
        WIN_IO   = 3'b010,
        WIN_SPM  = 3'b100
    } csr_window_t;
endpackage
`default_nettype wire

// ==== csr_cpu_special_registers.sv ====
// Notes on behaviour
// - a valid key opens a protection window for the next four instructions
// - 0x9D unlocks self-programming, 0xD8 unlocks protected I/O registers
// - no interrupt taken while a window is open; pending ones taken afterwards
// - key bit 0 reads one in I/O window, bit 1 in self-program window
// - key bits 7:2 always read zero
// - NVM access or sleep closes an open window at once; a memory write closes only the I/O window
// - stack pointer resets to the top SRAM address
// - only needed stack pointer bits stored; upper bits fixed to keep it in SRAM
// - stack pointer low byte at base offset, high byte at base plus one
// - low byte write blocks interrupts four instructions or until next I/O write
// - status bit 7 is global interrupt enable gating all interrupts
// - interrupt entry and return leave the enable bit alone; software only
// - changing enable bit by I/O access adds one wait cycle
// - status bit 6 is bit-load source and bit-store destination
// - status bit 5 tracks half carry of supporting operations
// - status bit 4 loads negative xor overflow on each ALU update of bits 3..0; a half-carry-only update leaves it
// - bits 3..0 hold overflow, negative, zero, carry of the last result
// - extended pointer byte forms address bits 23:16 above the 16-bit pointer
// - unimplemented extended pointer bits read as zero
// - plain program-memory load ignores the extended pointer byte
// - a selectable 32 KB flash section appears at data 0x8000..0xFFFF
// - program-memory load and self-programming address flash from zero
// - flash is 16-bit words in 256 pages of 512 bytes
`timescale 1ns/1ps
`default_nettype none
module csr_cpu_special_registers #(
    parameter int SP_BITS    = 14,
    parameter int EXT_BITS   = 1,
    parameter int FLASH_BITS = 17
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire csr_pkg::csr_io_req_t   io_req,
    output logic [7:0]                  io_rdata,
    output logic                        io_wait,
    input  wire logic                   instr_done,
    input  wire logic                   io_mem_wr,
    input  wire logic                   data_mem_wr,
    input  wire logic                   nvm_access,
    input  wire logic                   sleep_exec,
    input  wire logic                   set_interrupt_enable_instr,
    input  wire logic                   clear_interrupt_enable_instr,
    input  wire csr_pkg::csr_alu_flags_t alu_flags,
    input  wire logic                   bit_store_instr,
    input  wire logic                   bit_store_val,
    output logic                        bit_load_val,
    input  wire logic                   sp_push,
    input  wire logic                   sp_pop,
    input  wire logic                   irq_pending,
    output logic                        irq_take,
    output logic                        io_unlock_active,
    output logic                        self_program_active,
    output logic [15:0]                 stack_pointer,
    output logic [7:0]                  processor_status_flags,
    input  wire logic [15:0]            z_pointer,
    output logic [23:0]                 extended_address,
    output logic [23:0]                 program_memory_load_address,
    input  wire logic [15:0]            data_address,
    input  wire logic [1:0]             flash_section,
    output logic                        data_flash_hit,
    output logic [FLASH_BITS-1:0]       data_flash_byte,
    output logic [FLASH_BITS-2:0]       flash_word_address,
    output logic [7:0]                  flash_page
);
    generate
        if (SP_BITS < 8 || SP_BITS > 16) begin : g_bad_sp
            $error("SP_BITS must lie in 8..16");
        end
        if (EXT_BITS < 1 || EXT_BITS > 8) begin : g_bad_ext
            $error("EXT_BITS must lie in 1..8");
        end
        if (FLASH_BITS < 17 || FLASH_BITS > 24) begin : g_bad_flash
            $error("FLASH_BITS must lie in 17..24");
        end
        // extended byte must reach every flash address bit
        if (FLASH_BITS > 16 + EXT_BITS) begin : g_bad_reach
            $error("EXT_BITS too small for FLASH_BITS");
        end
        // page number output is eight bits
        if ((1 << (FLASH_BITS - csr_pkg::FLASH_PAGE_BITS)) > csr_pkg::FLASH_PAGES) begin : g_bad_page
            $error("FLASH_BITS gives too many pages");
        end
    endgenerate

    // masks of the implemented pointer bits
    localparam logic [15:0] SP_KEEP = 16'((32'h1 << SP_BITS) - 1);
    localparam logic [7:0] EXT_KEEP = 8'((32'h1 << EXT_BITS) - 1);

    function automatic logic is_wr(input csr_pkg::csr_io_req_t r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // a window or guard ends on the instruction that empties its count
    function automatic logic is_last(input logic [2:0] cnt);
        return cnt == 3'h1;
    endfunction

    // fixed upper bits keep the pointer inside SRAM
    function automatic logic [15:0] sp_fix(input logic [15:0] v);
        return (v & SP_KEEP) | (csr_pkg::SRAM_TOP & ~SP_KEEP);
    endfunction

    // protection window
    csr_pkg::csr_window_t win;
    csr_pkg::csr_window_t next_win;
    logic [2:0] win_cnt;
    logic [2:0] next_win_cnt;
    logic       key_wr;
    logic       other_wr;
    logic       cancel_any;

    assign key_wr     = is_wr(io_req, csr_pkg::OFF_KEY);
    assign other_wr   = (io_req.wr && !key_wr) || io_mem_wr || data_mem_wr;
    assign cancel_any = nvm_access || sleep_exec;

    always_comb begin
        next_win     = win;
        next_win_cnt = win_cnt;
        unique case (win)
            csr_pkg::WIN_IDLE: begin
            end
            // any non-key write ends the I/O window early
            csr_pkg::WIN_IO: begin
                if (other_wr || cancel_any) begin
                    next_win = csr_pkg::WIN_IDLE;
                end else if (instr_done) begin
                    next_win_cnt = win_cnt - 3'h1;
                    if (is_last(win_cnt)) begin
                        next_win = csr_pkg::WIN_IDLE;
                    end
                end
            end
            // memory writes leave the self-program window open
            csr_pkg::WIN_SPM: begin
                if (cancel_any) begin
                    next_win = csr_pkg::WIN_IDLE;
                end else if (instr_done) begin
                    next_win_cnt = win_cnt - 3'h1;
                    if (is_last(win_cnt)) begin
                        next_win = csr_pkg::WIN_IDLE;
                    end
                end
            end
            default: begin
                next_win = csr_pkg::WIN_IDLE;
            end
        endcase
        // a key write wins over a same-cycle cancel or count
        if (key_wr) begin
            if (io_req.wdata == csr_pkg::IO_UNLOCK_SIGNATURE) begin
                next_win     = csr_pkg::WIN_IO;
                next_win_cnt = csr_pkg::WINDOW_INSTRS;
            end else if (io_req.wdata == csr_pkg::SELF_PROGRAM_SIGNATURE) begin
                next_win     = csr_pkg::WIN_SPM;
                next_win_cnt = csr_pkg::WINDOW_INSTRS;
            end else begin
                next_win = csr_pkg::WIN_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            win     <= csr_pkg::WIN_IDLE;
            win_cnt <= 3'h0;
        end else begin
            win     <= next_win;
            win_cnt <= next_win_cnt;
        end
    end

    assign io_unlock_active    = (win == csr_pkg::WIN_IO);
    assign self_program_active = (win == csr_pkg::WIN_SPM);

    // stack pointer and its write guard
    logic [15:0] sp;
    logic [15:0] next_sp;
    logic        guard;
    logic        next_guard;
    logic [2:0]  guard_cnt;
    logic [2:0]  next_guard_cnt;
    logic        spl_wr;

    assign spl_wr = is_wr(io_req, csr_pkg::OFF_SP_LOW);

    always_comb begin
        next_sp = sp;
        // byte writes win over a same-cycle push or pop
        if (spl_wr) begin
            next_sp = sp_fix({sp[15:8], io_req.wdata});
        end else if (is_wr(io_req, csr_pkg::OFF_SP_HIGH)) begin
            next_sp = sp_fix({io_req.wdata, sp[7:0]});
        end else if (sp_push) begin
            next_sp = sp_fix(sp - 16'h0001);
        end else if (sp_pop) begin
            next_sp = sp_fix(sp + 16'h0001);
        end
        next_guard     = guard;
        next_guard_cnt = guard_cnt;
        // the low byte write restarts the guard rather than ending it
        if (spl_wr) begin
            next_guard     = 1'b1;
            next_guard_cnt = csr_pkg::WINDOW_INSTRS;
        end else if (guard) begin
            if (io_req.wr || io_mem_wr) begin
                next_guard = 1'b0;
            end else if (instr_done) begin
                next_guard_cnt = guard_cnt - 3'h1;
                if (is_last(guard_cnt)) begin
                    next_guard = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sp        <= csr_pkg::SRAM_TOP;
            guard     <= 1'b0;
            guard_cnt <= 3'h0;
        end else begin
            sp        <= next_sp;
            guard     <= next_guard;
            guard_cnt <= next_guard_cnt;
        end
    end

    assign stack_pointer = sp;

    // status flags and extended pointer
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] ext;
    logic [7:0] next_ext;
    logic       flags_wr;

    assign flags_wr = is_wr(io_req, csr_pkg::OFF_FLAGS);

    always_comb begin
        next_flags = flags;
        // a register write wins over instruction and ALU updates
        if (flags_wr) begin
            next_flags = io_req.wdata;
        end else begin
            // interrupt entry and return have no path here
            if (set_interrupt_enable_instr) begin
                next_flags[csr_pkg::FLAG_I] = 1'b1;
            end else if (clear_interrupt_enable_instr) begin
                next_flags[csr_pkg::FLAG_I] = 1'b0;
            end
            if (bit_store_instr) begin
                next_flags[csr_pkg::FLAG_T] = bit_store_val;
            end
            if (alu_flags.upd_h) begin
                next_flags[csr_pkg::FLAG_H] = alu_flags.h;
            end
            if (alu_flags.upd_vnzc) begin
                next_flags[csr_pkg::FLAG_V] = alu_flags.v;
                next_flags[csr_pkg::FLAG_N] = alu_flags.n;
                next_flags[csr_pkg::FLAG_Z] = alu_flags.z;
                next_flags[csr_pkg::FLAG_C] = alu_flags.c;
                next_flags[csr_pkg::FLAG_S] = alu_flags.n ^ alu_flags.v;
            end
        end
        // unimplemented extended bits are never stored
        next_ext = ext;
        if (is_wr(io_req, csr_pkg::OFF_EXT_PTR)) begin
            next_ext = io_req.wdata & EXT_KEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= csr_pkg::FLAGS_RESET;
            ext   <= csr_pkg::EXT_RESET;
        end else begin
            flags <= next_flags;
            ext   <= next_ext;
        end
    end

    assign processor_status_flags = flags;
    assign bit_load_val           = flags[csr_pkg::FLAG_T];

    // one wait cycle when an I/O write flips the enable bit
    // the write still lands on the same edge
    assign io_wait = flags_wr &&
                     (io_req.wdata[csr_pkg::FLAG_I] != flags[csr_pkg::FLAG_I]);

    // interrupts held off by the enable bit, open window or stack guard
    // a held-off request stays pending and is taken once the hold-off ends
    assign irq_take = irq_pending && flags[csr_pkg::FLAG_I] &&
                      (win == csr_pkg::WIN_IDLE) && !guard;

    // read data
    logic [7:0] next_rdata;

    always_comb begin
        // read data holds until the next read
        next_rdata = io_rdata;
        if (io_req.rd) begin
            unique case (io_req.addr)
                // only the two window bits are live
                csr_pkg::OFF_KEY: begin
                    next_rdata = csr_pkg::KEY_RESET;
                    next_rdata[csr_pkg::KEY_IO_BIT]  = io_unlock_active;
                    next_rdata[csr_pkg::KEY_SPM_BIT] = self_program_active;
                end
                csr_pkg::OFF_EXT_PTR: begin
                    next_rdata = ext;
                end
                csr_pkg::OFF_SP_LOW: begin
                    next_rdata = sp[7:0];
                end
                csr_pkg::OFF_SP_HIGH: begin
                    next_rdata = sp[15:8];
                end
                csr_pkg::OFF_FLAGS: begin
                    next_rdata = flags;
                end
                // unmapped offsets read zero
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else begin
            io_rdata <= next_rdata;
        end
    end

    // flash addressing, one register stage like the other data outputs
    logic [23:0]           next_extended_address;
    logic [23:0]           next_program_memory_load_address;
    logic                  next_data_flash_hit;
    logic [FLASH_BITS-1:0] next_data_flash_byte;
    logic [FLASH_BITS-2:0] next_flash_word_address;
    logic [7:0]            next_flash_page;

    always_comb begin
        next_extended_address            = {ext, z_pointer};
        next_program_memory_load_address = {8'h00, z_pointer};
        next_data_flash_hit              = (data_address >= csr_pkg::FLASH_DATA_BASE);
        next_data_flash_byte             = FLASH_BITS'({flash_section,
                                           data_address[csr_pkg::FLASH_SECTION_BITS-1:0]});
        next_flash_word_address          = next_extended_address[FLASH_BITS-1:1];
        next_flash_page                  = next_extended_address[csr_pkg::FLASH_PAGE_BITS +: 8];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            extended_address            <= 24'h00_0000;
            program_memory_load_address <= 24'h00_0000;
            data_flash_hit              <= 1'b0;
            data_flash_byte             <= '0;
            flash_word_address          <= '0;
            flash_page                  <= 8'h00;
        end else begin
            extended_address            <= next_extended_address;
            program_memory_load_address <= next_program_memory_load_address;
            data_flash_hit              <= next_data_flash_hit;
            data_flash_byte             <= next_data_flash_byte;
            flash_word_address          <= next_flash_word_address;
            flash_page                  <= next_flash_page;
        end
    end
endmodule
`default_nettype wire

// ==== csr_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module csr_checker (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire csr_pkg::csr_io_req_t    io_req,
    input wire logic [7:0]              io_rdata,
    input wire logic                    io_wait,
    input wire csr_pkg::csr_alu_flags_t alu_flags,
    input wire logic                    sleep_exec,
    input wire logic                    clear_interrupt_enable_instr,
    input wire logic                    irq_take,
    input wire logic                    io_unlock_active,
    input wire logic                    self_program_active,
    input wire logic [7:0]              processor_status_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    key_read_a: assert property (
        io_req.rd && io_req.addr == csr_pkg::OFF_KEY |=>
        io_rdata == {6'h00, $past(self_program_active), $past(io_unlock_active)})
        else $error("key read bits wrong");
    win_irq_a: assert property (
        io_unlock_active || self_program_active |-> !irq_take)
        else $error("interrupt taken in window");
    sleep_close_a: assert property (
        sleep_exec && !io_req.wr |=> !io_unlock_active && !self_program_active)
        else $error("sleep left window open");
    sp_guard_a: assert property (
        io_req.wr && io_req.addr == csr_pkg::OFF_SP_LOW |=> !irq_take)
        else $error("interrupt right after sp write");
    irq_gate_a: assert property (
        !processor_status_flags[7] |-> !irq_take)
        else $error("interrupt with enable clear");
    irq_keep_a: assert property (
        irq_take && !io_req.wr && !clear_interrupt_enable_instr |=> processor_status_flags[7])
        else $error("enable changed by interrupt entry");
    io_wait_a: assert property (
        io_req.wr && io_req.addr == csr_pkg::OFF_FLAGS &&
        io_req.wdata[7] != processor_status_flags[7] |-> io_wait)
        else $error("no wait on enable change");
    flag_sign_a: assert property (
        alu_flags.upd_vnzc && !io_req.wr |=> processor_status_flags[3] == $past(alu_flags.v) &&
        processor_status_flags[4] == (processor_status_flags[3] ^ processor_status_flags[2]))
        else $error("sign flag mismatch");
endmodule
bind csr_cpu_special_registers csr_checker i_csr_checker (
    .clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .io_wait(io_wait),
    .alu_flags(alu_flags), .sleep_exec(sleep_exec), .irq_take(irq_take),
    .clear_interrupt_enable_instr(clear_interrupt_enable_instr),
    .io_unlock_active(io_unlock_active), .self_program_active(self_program_active),
    .processor_status_flags(processor_status_flags));
`default_nettype wire

// ==== csr_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                    clk, rst, instr_done, io_mem_wr, data_mem_wr, nvm_access, sleep_exec;
    logic                    set_interrupt_enable_instr, clear_interrupt_enable_instr, bit_store_instr;
    logic                    bit_store_val, bit_load_val, sp_push, sp_pop, irq_pending, irq_take;
    logic                    io_wait, io_unlock_active, self_program_active, data_flash_hit;
    logic [1:0]              flash_section;
    logic [7:0]              io_rdata, processor_status_flags, flash_page;
    logic [15:0]             stack_pointer, z_pointer, data_address, flash_word_address;
    logic [16:0]             data_flash_byte;
    logic [23:0]             extended_address, program_memory_load_address;
    csr_pkg::csr_io_req_t    io_req;
    csr_pkg::csr_alu_flags_t alu_flags;
    int                      n_fail, checks_done;
    csr_cpu_special_registers i_csr_cpu_special_registers (
        .clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .io_wait(io_wait),
        .instr_done(instr_done), .io_mem_wr(io_mem_wr), .data_mem_wr(data_mem_wr), .nvm_access(nvm_access),
        .sleep_exec(sleep_exec), .set_interrupt_enable_instr(set_interrupt_enable_instr),
        .clear_interrupt_enable_instr(clear_interrupt_enable_instr), .alu_flags(alu_flags),
        .bit_store_instr(bit_store_instr), .bit_store_val(bit_store_val), .bit_load_val(bit_load_val),
        .sp_push(sp_push), .sp_pop(sp_pop), .irq_pending(irq_pending), .irq_take(irq_take),
        .io_unlock_active(io_unlock_active), .self_program_active(self_program_active),
        .stack_pointer(stack_pointer), .processor_status_flags(processor_status_flags),
        .z_pointer(z_pointer), .extended_address(extended_address),
        .program_memory_load_address(program_memory_load_address), .data_address(data_address),
        .flash_section(flash_section), .data_flash_hit(data_flash_hit), .data_flash_byte(data_flash_byte),
        .flash_word_address(flash_word_address), .flash_page(flash_page));
    always #10 clk = ~clk;
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(negedge clk) io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk) io_req.wr = 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
        @(negedge clk) io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk) io_req.rd = 1'b0;
        chk(what, {16'h0000, exp}, {16'h0000, io_rdata});
    endtask
    task automatic step(int n);
        repeat (n) begin
            @(negedge clk) instr_done = 1'b1;
            @(negedge clk) instr_done = 1'b0;
        end
    endtask
    task automatic t_reset;
        rd(csr_pkg::OFF_KEY, 8'h00, "key");
        rd(csr_pkg::OFF_EXT_PTR, 8'h00, "ext");
        rd(csr_pkg::OFF_SP_LOW, 8'hff, "sp low");
        rd(csr_pkg::OFF_SP_HIGH, 8'h7f, "sp high");
        rd(csr_pkg::OFF_FLAGS, 8'h00, "flags");
        rd(4'h0, 8'h00, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_window;
        wr(csr_pkg::OFF_FLAGS, 8'h80);
        irq_pending = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(csr_pkg::OFF_KEY, k ? csr_pkg::SELF_PROGRAM_SIGNATURE : csr_pkg::IO_UNLOCK_SIGNATURE);
            rd(csr_pkg::OFF_KEY, k ? 8'h02 : 8'h01, "key bits");
            step(3);
            chk("held irq", 24'h0, {23'h0, irq_take});
            chk("open", 24'h1, {23'h0, io_unlock_active | self_program_active});
            step(1);
            chk("closed", 24'h0, {23'h0, io_unlock_active | self_program_active});
            chk("late irq", 24'h1, {23'h0, irq_take});
        end
        $display("window test done");
    endtask
    task automatic t_close;
        wr(csr_pkg::OFF_KEY, 8'h55);
        chk("bad key", 24'h0, {22'h0, io_unlock_active, self_program_active});
        wr(csr_pkg::OFF_KEY, csr_pkg::IO_UNLOCK_SIGNATURE);
        @(negedge clk) data_mem_wr = 1'b1;
        @(negedge clk) data_mem_wr = 1'b0;
        chk("io by store", 24'h0, {23'h0, io_unlock_active});
        wr(csr_pkg::OFF_KEY, csr_pkg::SELF_PROGRAM_SIGNATURE);
        @(negedge clk) data_mem_wr = 1'b1;
        @(negedge clk) data_mem_wr = 1'b0;
        chk("spm kept", 24'h1, {23'h0, self_program_active});
        @(negedge clk) nvm_access = 1'b1;
        @(negedge clk) nvm_access = 1'b0;
        chk("spm by nvm", 24'h0, {23'h0, self_program_active});
        wr(csr_pkg::OFF_KEY, csr_pkg::IO_UNLOCK_SIGNATURE);
        @(negedge clk) sleep_exec = 1'b1;
        @(negedge clk) sleep_exec = 1'b0;
        chk("io by sleep", 24'h0, {23'h0, io_unlock_active});
        $display("close test done");
    endtask
    task automatic t_sp;
        wr(csr_pkg::OFF_SP_LOW, 8'h34);
        chk("guard", 24'h0, {23'h0, irq_take});
        step(3);
        chk("guard 3", 24'h0, {23'h0, irq_take});
        step(1);
        chk("guard 4", 24'h1, {23'h0, irq_take});
        wr(csr_pkg::OFF_SP_LOW, 8'h35);
        @(negedge clk) io_mem_wr = 1'b1;
        @(negedge clk) io_mem_wr = 1'b0;
        chk("guard io", 24'h1, {23'h0, irq_take});
        irq_pending = 1'b0;
        wr(csr_pkg::OFF_SP_HIGH, 8'h00);
        chk("sp", 24'h00_4035, {8'h00, stack_pointer});
        @(negedge clk) sp_push = 1'b1;
        @(negedge clk) sp_push = 1'b0;
        rd(csr_pkg::OFF_SP_LOW, 8'h34, "push low");
        rd(csr_pkg::OFF_SP_HIGH, 8'h40, "push high");
        @(negedge clk) sp_pop = 1'b1;
        @(negedge clk) sp_pop = 1'b0;
        chk("pop", 24'h00_4035, {8'h00, stack_pointer});
        $display("stack test done");
    endtask
    task automatic t_flags;
        @(negedge clk) io_req = '{wr: 1'b1, rd: 1'b0, addr: csr_pkg::OFF_FLAGS, wdata: 8'h00};
        #1 chk("wait", 24'h1, {23'h0, io_wait});
        @(negedge clk) io_req.wr = 1'b0;
        @(negedge clk) set_interrupt_enable_instr = 1'b1;
        @(negedge clk) set_interrupt_enable_instr = 1'b0;
        chk("set", 24'h80, {16'h0000, processor_status_flags});
        @(negedge clk) clear_interrupt_enable_instr = 1'b1;
        @(negedge clk) clear_interrupt_enable_instr = 1'b0;
        chk("clear", 24'h00, {16'h0000, processor_status_flags});
        @(negedge clk) alu_flags = 7'h75;
        @(negedge clk) alu_flags = 7'h6e;
        chk("alu one", 24'h35, {16'h0000, processor_status_flags});
        @(negedge clk) alu_flags = '0;
        chk("alu two", 24'h0e, {16'h0000, processor_status_flags});
        @(negedge clk) {bit_store_instr, bit_store_val} = 2'h3;
        @(negedge clk) {bit_store_instr, bit_store_val} = 2'h0;
        chk("bit load", 24'h1, {23'h0, bit_load_val});
        rd(csr_pkg::OFF_FLAGS, 8'h4e, "flags");
        $display("flags test done");
    endtask
    task automatic t_ext;
        wr(csr_pkg::OFF_EXT_PTR, 8'hff);
        rd(csr_pkg::OFF_EXT_PTR, 8'h01, "ext");
        @(negedge clk) {z_pointer, data_address, flash_section} = {16'hfffe, 16'h9234, 2'h2};
        @(negedge clk) chk("ext addr", 24'h01_fffe, extended_address);
        chk("load addr", 24'h00_fffe, program_memory_load_address);
        chk("hit", 24'h1, {23'h0, data_flash_hit});
        chk("flash byte", 24'h01_1234, {7'h0, data_flash_byte});
        chk("word", 24'h00_ffff, {8'h00, flash_word_address});
        chk("page", 24'hff, {16'h0000, flash_page});
        @(negedge clk) data_address = 16'h7fff;
        @(negedge clk) chk("miss", 24'h0, {23'h0, data_flash_hit});
        $display("pointer test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {instr_done, io_mem_wr, data_mem_wr, nvm_access, sleep_exec, sp_push, sp_pop} = '0;
        {set_interrupt_enable_instr, clear_interrupt_enable_instr, bit_store_instr, bit_store_val} = '0;
        {irq_pending, flash_section, z_pointer, data_address} = '0;
        io_req = '0;
        alu_flags = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_window;
        t_close;
        t_sp;
        t_flags;
        t_ext;
        results;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results;
    end
endmodule
`default_nettype wire
